// file: common/hvmcr_pkg.sv
// Behaviour
// RULE1 - Quiet mode register writable only while write-enable bit 9 or coil 9 set.
// RULE2 - Quiet register value 0 disables, 1 enables; coil 18 does the same.
// RULE3 - Quiet mode only moves the outdoor fan temperature target.
// RULE4 - Write-enable bits 3 and 10 unlock indoor fan and dehumidify registers.
// RULE5 - Indoor fan bit 0: 0 variable speed, 1 fixed speed.
// RULE6 - Dehumidify register 0 turns dry mode off, 1 turns it on.
// RULE7 - Valve value 3 means dual valves; writable after write-enable bit 4.
// RULE8 - Dual-valve units need valve value 1 for conventional drying, else super; the code gives super only while indoor fan bit 0 is 0.
// RULE9 - Super drying uses valves at fixed fan; fan varies only if target missed.
// RULE10 - Three faults of one kind within sliding 12 hours cause lockout.
// RULE11 - During lockout compressor, indoor fan and outdoor fan stay off.
// RULE12 - Normal unit switch-off clears all fault counts.
// RULE13 - Operating state reads 12 while locked out.
// RULE14 - Keys 0x55aa then 0x0f0f by function 6 within 10 seconds clear lockout.
// RULE15 - Power cycle or completed system reset sequence clears lockout.
// RULE16 - System reset: 0x2275 to arm key register, then 0x1234 to command key.
// RULE17 - Completed reset sequence restarts the whole system like power-on.
// RULE18 - Read offsets 0, 2000, 4000, 6000 select master and slaves 1 to 3.
// RULE19 - Offset addresses accept only read function 03.
// RULE20 - Slave reads are relayed with at most 1 second extra delay.
// RULE21 - All other holding registers are read-only to the host.
// RULE22 - Gated writes with enable bit clear are ignored, value unchanged.
package hvmcr_pkg;
  // Register addresses
  localparam logic [15:0] ADDR_HOST_WRITE_ENABLE = 16'h0065;
  localparam logic [15:0] ADDR_INDOOR_FAN_BEHAVIOUR = 16'h0069;
  localparam logic [15:0] ADDR_VALVE_ARRANGEMENT = 16'h006a;
  localparam logic [15:0] ADDR_LOW_NOISE_SELECT = 16'h006f;
  localparam logic [15:0] ADDR_DEHUMIDIFY_SELECT = 16'h0070;
  localparam logic [15:0] ADDR_OPERATING_STATE = 16'h0197;
  localparam logic [15:0] ADDR_RESET_ARM_KEY = 16'h0579;
  localparam logic [15:0] ADDR_COMMAND_KEY = 16'h076d;
  // Coil numbers
  localparam logic [15:0] COIL_QUIET_ENABLE = 16'h0009;
  localparam logic [15:0] COIL_QUIET_SELECT = 16'h0012;
  // Write-enable bit positions
  localparam int WE_BIT_FAN = 3;
  localparam int WE_BIT_VALVE = 4;
  localparam int WE_BIT_QUIET = 9;
  localparam int WE_BIT_DRY = 10;
  // Values and keys
  localparam logic [15:0] VALVE_CONVENTIONAL = 16'h0001;
  localparam logic [15:0] VALVE_DUAL = 16'h0003;
  localparam logic [15:0] STATE_LOCKOUT = 16'h000c;
  localparam logic [15:0] KEY_UNLOCK_1 = 16'h55aa;
  localparam logic [15:0] KEY_UNLOCK_2 = 16'h0f0f;
  localparam logic [15:0] KEY_RESET_ARM = 16'h2275;
  localparam logic [15:0] KEY_RESET_GO = 16'h1234;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Slave offsets
  localparam logic [15:0] OFS_SLAVE1 = 16'd2000;
  localparam logic [15:0] OFS_SLAVE2 = 16'd4000;
  localparam logic [15:0] OFS_SLAVE3 = 16'd6000;
  // Function and exception codes
  localparam logic [7:0] FN_READ_HOLDING = 8'h03;
  localparam logic [7:0] FN_WRITE_COIL = 8'h05;
  localparam logic [7:0] FN_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_GATEWAY_TIMEOUT = 8'h0b;
  // Timing and fault counts
  localparam int CLK_HZ = 25_000_000;
  localparam int KEY_WINDOW_S = 10;
  localparam int RELAY_MAX_S = 1;
  localparam int FAULT_WINDOW_H = 12;
  localparam int FAULT_WINDOW_SEC = FAULT_WINDOW_H * 3600;
  localparam int SEC_CYC = CLK_HZ;
  localparam int KEY_WINDOW_CYC = KEY_WINDOW_S * CLK_HZ;
  localparam int RELAY_MAX_CYC = RELAY_MAX_S * CLK_HZ;
  localparam int NFAULT = 4;
  localparam int TRIP_COUNT = 3;

  typedef enum logic [0:0] {RLY_IDLE, RLY_WAIT} hvmcr_rly_t;

  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } hvmcr_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] exc;
    logic [15:0] data;
  } hvmcr_rsp_t;

  typedef struct packed {
    logic valid;
    logic [1:0] slave;
    logic [15:0] addr;
  } hvmcr_relay_t;

  typedef struct packed {
    logic ok;
    logic [15:0] age;
  } hvmcr_fault_t;

  typedef struct packed {
    logic comp_en;
    logic indoor_fan_en;
    logic outdoor_fan_en;
    logic outdoor_target_quiet;
    logic fan_fixed;
    logic dry_on;
    logic evap_by_valves;
    logic fan_vary;
    logic super_dry;
    logic locked;
  } hvmcr_act_t;

  typedef struct packed {
    logic [15:0] write_enable;
    logic [15:0] fan_beh;
    logic [15:0] valve;
    logic [15:0] low_noise;
    logic [15:0] dehum;
    logic locked;
    logic key1_seen;
    logic [27:0] key_cnt;
    logic rst_armed;
    logic [24:0] sec_cnt;
    hvmcr_fault_t [NFAULT-1:0][TRIP_COUNT-2:0] fault;
    hvmcr_rly_t rly;
    logic [24:0] rly_cnt;
    logic ready;
    hvmcr_rsp_t rsp;
    hvmcr_relay_t relay;
    logic restart;
    hvmcr_act_t act;
  } hvmcr_state_t;
endpackage

// file: src/hvmcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module hvmcr_regs import hvmcr_pkg::*; #(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int KEY_CYCLES = KEY_WINDOW_CYC,
  parameter int RELAY_CYCLES = RELAY_MAX_CYC,
  parameter int FAULT_WINDOW = FAULT_WINDOW_SEC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Decoded host request and answer
  input wire hvmcr_req_t host_req_in,
  output logic host_ready_out,
  output hvmcr_rsp_t host_rsp_out,
  // Slave relay link
  output hvmcr_relay_t relay_req_out,
  input wire logic slave_rsp_valid_in,
  input wire logic [15:0] slave_rsp_data_in,
  // Controller status
  input wire logic [NFAULT-1:0] fault_event_in,
  input wire logic unit_off_normal_in,
  input wire logic [15:0] unit_mode_in,
  input wire logic dual_valve_model_in,
  input wire logic evap_target_missed_in,
  input wire logic comp_request_in,
  input wire logic indoor_fan_request_in,
  input wire logic outdoor_fan_request_in,
  // Actuator and restart outputs
  output hvmcr_act_t act_out,
  output logic system_restart_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Slave index selected by an address offset
  function automatic logic [1:0] slave_of(input logic [15:0] a);
    if (a >= OFS_SLAVE3) begin
      slave_of = 2'h3;
    end else if (a >= OFS_SLAVE2) begin
      slave_of = 2'h2;
    end else if (a >= OFS_SLAVE1) begin
      slave_of = 2'h1;
    end else begin
      slave_of = 2'h0;
    end
  endfunction

  // Write-enable bit that gates a mode register
  function automatic logic gate_ok(input logic [15:0] a, input logic [15:0] we);
    case (a)
      ADDR_INDOOR_FAN_BEHAVIOUR: gate_ok = we[WE_BIT_FAN];
      ADDR_VALVE_ARRANGEMENT: gate_ok = we[WE_BIT_VALVE];
      ADDR_LOW_NOISE_SELECT: gate_ok = we[WE_BIT_QUIET];
      ADDR_DEHUMIDIFY_SELECT: gate_ok = we[WE_BIT_DRY];
      default: gate_ok = 1'b1;
    endcase
  endfunction

  // Value subtracted from a relayed address
  function automatic logic [15:0] offset_of(input logic [1:0] s);
    case (s)
      2'h1: offset_of = OFS_SLAVE1;
      2'h2: offset_of = OFS_SLAVE2;
      2'h3: offset_of = OFS_SLAVE3;
      default: offset_of = REG_RESET;
    endcase
  endfunction

  localparam logic [24:0] SEC_LAST = 25'(SEC_CYCLES - 1);
  localparam logic [27:0] KEY_LIMIT = 28'(KEY_CYCLES);
  localparam logic [24:0] RELAY_LIMIT = 25'(RELAY_CYCLES);
  localparam logic [15:0] WINDOW_AGE = 16'(FAULT_WINDOW);

  hvmcr_state_t st_q;
  hvmcr_state_t st_d;
  hvmcr_state_t st_rst;

  logic accept;
  logic is_rd;
  logic is_wr;
  logic is_coil;
  logic [1:0] req_slave;
  logic sec_tick;
  logic [1:0] young;
  logic dry;
  logic fixed_fan;
  logic dual_ok;
  logic trip;

  ////////////////////////////////////////////////////////////////////////////
  // Reset image
  always_comb begin
    st_rst = '0;
    st_rst.rly = RLY_IDLE;
    st_rst.ready = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    young = 2'h0;
    trip = 1'b0;
    st_d.rsp = '0;
    st_d.relay.valid = 1'b0;
    st_d.restart = 1'b0;
    accept = host_req_in.valid && st_q.ready;
    is_rd = host_req_in.func == FN_READ_HOLDING;
    is_wr = host_req_in.func == FN_WRITE_SINGLE;
    is_coil = host_req_in.func == FN_WRITE_COIL;
    req_slave = slave_of(host_req_in.addr);

    // Second time base
    sec_tick = st_q.sec_cnt == SEC_LAST;
    st_d.sec_cnt = sec_tick ? '0 : st_q.sec_cnt + 25'h1;

    // Unlock key window
    if (st_q.key1_seen) begin
      if (st_q.key_cnt >= KEY_LIMIT) begin
        st_d.key1_seen = 1'b0; // RULE14
      end else begin
        st_d.key_cnt = st_q.key_cnt + 28'h1;
      end
    end

    // Fault history per condition
    for (int f = 0; f < NFAULT; f++) begin
      for (int e = 0; e < TRIP_COUNT - 1; e++) begin
        if (sec_tick && st_q.fault[f][e].ok) begin
          st_d.fault[f][e].age = st_q.fault[f][e].age + 16'h1;
          if (st_q.fault[f][e].age + 16'h1 >= WINDOW_AGE) begin
            st_d.fault[f][e].ok = 1'b0; // RULE10
          end
        end
      end
      if (fault_event_in[f]) begin
        young = 2'h0;
        for (int e = 0; e < TRIP_COUNT - 1; e++) begin
          young = young + {1'b0, st_d.fault[f][e].ok};
        end
        if (young == 2'(TRIP_COUNT - 1)) begin
          trip = 1'b1; // RULE10
        end
        for (int e = TRIP_COUNT - 2; e > 0; e--) begin
          st_d.fault[f][e] = st_d.fault[f][e-1];
        end
        st_d.fault[f][0].ok = 1'b1;
        st_d.fault[f][0].age = '0;
      end
    end
    if (unit_off_normal_in) begin
      st_d.fault = '0; // RULE12
    end

    // Relay wait
    if (st_q.rly == RLY_WAIT) begin
      st_d.rly_cnt = st_q.rly_cnt + 25'h1;
      if (slave_rsp_valid_in) begin
        st_d.rsp.valid = 1'b1; // RULE20
        st_d.rsp.data = slave_rsp_data_in;
        st_d.rly = RLY_IDLE;
      end else if (st_q.rly_cnt >= RELAY_LIMIT - 25'h1) begin
        st_d.rsp.valid = 1'b1; // RULE20
        st_d.rsp.exc = EXC_GATEWAY_TIMEOUT;
        st_d.rly = RLY_IDLE;
      end
    end

    // Host request decode
    if (accept) begin
      st_d.rsp.valid = 1'b1;
      st_d.rsp.data = host_req_in.data;
      if (req_slave != 2'h0 && !is_rd) begin
        st_d.rsp.exc = EXC_ILLEGAL_FUNCTION; // RULE19
      end else if (is_rd && req_slave != 2'h0) begin
        st_d.rsp.valid = 1'b0; // RULE18
        st_d.relay.valid = 1'b1;
        st_d.relay.slave = req_slave;
        st_d.relay.addr = host_req_in.addr - offset_of(req_slave);
        st_d.rly = RLY_WAIT;
        st_d.rly_cnt = '0;
      end else if (is_rd) begin
        case (host_req_in.addr)
          ADDR_HOST_WRITE_ENABLE: st_d.rsp.data = st_q.write_enable;
          ADDR_INDOOR_FAN_BEHAVIOUR: st_d.rsp.data = st_q.fan_beh;
          ADDR_VALVE_ARRANGEMENT: st_d.rsp.data = st_q.valve;
          ADDR_LOW_NOISE_SELECT: st_d.rsp.data = st_q.low_noise;
          ADDR_DEHUMIDIFY_SELECT: st_d.rsp.data = st_q.dehum;
          ADDR_OPERATING_STATE: begin
            st_d.rsp.data = st_q.locked ? STATE_LOCKOUT : unit_mode_in; // RULE13
          end
          default: st_d.rsp.data = REG_RESET;
        endcase
      end else if (is_coil) begin
        case (host_req_in.addr)
          COIL_QUIET_ENABLE: begin
            st_d.write_enable[WE_BIT_QUIET] = host_req_in.data == COIL_ON; // RULE1
          end
          COIL_QUIET_SELECT: begin
            if (st_q.write_enable[WE_BIT_QUIET]) begin
              st_d.low_noise = {15'h0, host_req_in.data == COIL_ON}; // RULE2
            end
          end
          default: st_d.rsp.exc = EXC_ILLEGAL_ADDRESS;
        endcase
      end else if (is_wr) begin
        case (host_req_in.addr)
          ADDR_HOST_WRITE_ENABLE: st_d.write_enable = host_req_in.data; // RULE4
          ADDR_INDOOR_FAN_BEHAVIOUR,
          ADDR_VALVE_ARRANGEMENT,
          ADDR_LOW_NOISE_SELECT,
          ADDR_DEHUMIDIFY_SELECT: begin
            if (gate_ok(host_req_in.addr, st_q.write_enable)) begin // RULE22
              case (host_req_in.addr)
                ADDR_INDOOR_FAN_BEHAVIOUR: st_d.fan_beh = host_req_in.data; // RULE4
                ADDR_VALVE_ARRANGEMENT: st_d.valve = host_req_in.data; // RULE7
                ADDR_LOW_NOISE_SELECT: st_d.low_noise = host_req_in.data; // RULE1
                default: st_d.dehum = host_req_in.data; // RULE4
              endcase
            end
          end
          ADDR_RESET_ARM_KEY: st_d.rst_armed = host_req_in.data == KEY_RESET_ARM; // RULE16
          ADDR_COMMAND_KEY: begin
            st_d.rst_armed = 1'b0;
            st_d.key1_seen = 1'b0;
            if (st_q.rst_armed && host_req_in.data == KEY_RESET_GO) begin
              st_d.restart = 1'b1; // RULE16
            end else if (host_req_in.data == KEY_UNLOCK_1) begin
              st_d.key1_seen = 1'b1; // RULE14
              st_d.key_cnt = '0;
            end else if (st_q.key1_seen && host_req_in.data == KEY_UNLOCK_2) begin
              st_d.locked = 1'b0; // RULE14
            end
          end
          default: st_d.rsp.exc = EXC_ILLEGAL_ADDRESS; // RULE21
        endcase
      end else begin
        st_d.rsp.exc = EXC_ILLEGAL_FUNCTION; // RULE21
      end
    end

    // Trip wins over a same-cycle unlock key
    if (trip) begin
      st_d.locked = 1'b1; // RULE10
    end

    // Full restart on completed reset sequence
    if (st_d.restart) begin
      st_d = st_rst; // RULE17
      st_d.restart = 1'b1; // RULE15
      st_d.rsp.valid = 1'b1;
      st_d.rsp.data = host_req_in.data;
    end
    st_d.ready = st_d.rly == RLY_IDLE;

    // Actuator drive
    dry = st_d.dehum[0]; // RULE6
    fixed_fan = st_d.fan_beh[0]; // RULE5
    dual_ok = dual_valve_model_in && st_d.valve != VALVE_CONVENTIONAL; // RULE8
    st_d.act.locked = st_d.locked;
    st_d.act.comp_en = comp_request_in && !st_d.locked; // RULE11
    st_d.act.indoor_fan_en = indoor_fan_request_in && !st_d.locked; // RULE11
    st_d.act.outdoor_fan_en = outdoor_fan_request_in && !st_d.locked; // RULE11
    st_d.act.outdoor_target_quiet = st_d.low_noise[0]; // RULE3
    st_d.act.fan_fixed = fixed_fan; // RULE5
    st_d.act.dry_on = dry; // RULE6
    st_d.act.super_dry = dry && !fixed_fan && dual_ok; // RULE8
    st_d.act.evap_by_valves = dry && dual_valve_model_in
                              && (fixed_fan ? st_d.valve == VALVE_DUAL : dual_ok); // RULE9
    st_d.act.fan_vary = dry && !fixed_fan && (!dual_ok || evap_target_missed_in); // RULE9
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= '0; // RULE15
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign host_ready_out = st_q.ready;
  assign host_rsp_out = st_q.rsp;
  assign relay_req_out = st_q.relay;
  assign act_out = st_q.act;
  assign system_restart_out = st_q.restart;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_lock_reads_12;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (host_req_in.valid && st_q.ready && st_q.locked && host_req_in.func == FN_READ_HOLDING
     && host_req_in.addr == ADDR_OPERATING_STATE) |=> (host_rsp_out.data == STATE_LOCKOUT);
  endproperty
  a_lock_reads_12: assert property (p_lock_reads_12) // RULE13
    else $error("lockout not read as 12");

  property p_lock_all_off;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    act_out.locked |-> !(act_out.comp_en || act_out.indoor_fan_en || act_out.outdoor_fan_en);
  endproperty
  a_lock_all_off: assert property (p_lock_all_off) else $error("actuator on in lockout"); // RULE11

  property p_quiet_gated;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (host_req_in.valid && st_q.ready && host_req_in.func == FN_WRITE_SINGLE
     && host_req_in.addr == ADDR_LOW_NOISE_SELECT && !st_q.write_enable[WE_BIT_QUIET])
    |=> $stable(st_q.low_noise);
  endproperty
  a_quiet_gated: assert property (p_quiet_gated) // RULE22
    else $error("gated quiet write took effect");

  property p_quiet_write;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (host_req_in.valid && st_q.ready && host_req_in.func == FN_WRITE_SINGLE
     && host_req_in.addr == ADDR_LOW_NOISE_SELECT && st_q.write_enable[WE_BIT_QUIET]
     && host_req_in.data == 16'h0001) |=> act_out.outdoor_target_quiet;
  endproperty
  a_quiet_write: assert property (p_quiet_write) else $error("quiet enable not applied"); // RULE2

  property p_restart_seq;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (host_req_in.valid && st_q.ready && st_q.rst_armed && host_req_in.func == FN_WRITE_SINGLE
     && host_req_in.addr == ADDR_COMMAND_KEY && host_req_in.data == KEY_RESET_GO)
    |=> (system_restart_out && !act_out.locked && st_q.write_enable == REG_RESET);
  endproperty
  a_restart_seq: assert property (p_restart_seq) // RULE17
    else $error("reset sequence did not restart");

  property p_relay_slave1;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (host_req_in.valid && st_q.ready && host_req_in.func == FN_READ_HOLDING
     && host_req_in.addr >= OFS_SLAVE1 && host_req_in.addr < OFS_SLAVE2)
    |=> (relay_req_out.valid && relay_req_out.slave == 2'h1 && !host_ready_out);
  endproperty
  a_relay_slave1: assert property (p_relay_slave1) // RULE18
    else $error("slave 1 read not relayed");

  property p_relay_bound;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (st_q.rly == RLY_WAIT) |-> (st_q.rly_cnt < RELAY_LIMIT);
  endproperty
  a_relay_bound: assert property (p_relay_bound) else $error("relay wait too long"); // RULE20

  property p_offset_func;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (host_req_in.valid && st_q.ready && host_req_in.func != FN_READ_HOLDING
     && host_req_in.addr >= OFS_SLAVE1) |=> (host_rsp_out.exc == EXC_ILLEGAL_FUNCTION);
  endproperty
  a_offset_func: assert property (p_offset_func) else $error("offset write not refused"); // RULE19

  property p_off_clears;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (unit_off_normal_in && !st_d.restart) |=> (st_q.fault == '0);
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("fault counts not cleared"); // RULE12

  property p_super_dry;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    act_out.super_dry |-> (act_out.dry_on && !act_out.fan_fixed);
  endproperty
  a_super_dry: assert property (p_super_dry) else $error("super drying on fixed fan"); // RULE8

  property p_super_valves;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    act_out.super_dry |-> act_out.evap_by_valves;
  endproperty
  a_super_valves: assert property (p_super_valves) // RULE9
    else $error("super drying without valves");

  c_lockout: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) $rose(st_q.locked));
  c_unlock: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) $fell(st_q.locked));
  c_restart: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) system_restart_out);
  c_relay: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    st_q.rly == RLY_WAIT && slave_rsp_valid_in);
endmodule
`default_nettype wire

// file: test/hvmcr_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module hvmcr_slave_model import hvmcr_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Relay link from the master
  input wire hvmcr_relay_t relay_req_in,
  input wire logic mute_in,
  input wire logic [7:0] delay_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out
);
  logic busy;
  logic [7:0] cnt;
  logic [15:0] val;
  // Answer each relayed read after the asked delay, or stay silent when muted
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      val <= 16'h0000;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 16'h0000;
    end else begin
      rsp_valid_out <= 1'b0;
      rsp_data_out <= ~rsp_data_out; // Released data line toggles
      if (relay_req_in.valid && !mute_in) begin
        busy <= 1'b1;
        cnt <= delay_in;
        val <= {relay_req_in.slave, relay_req_in.addr[13:0]} ^ 16'h5a00;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        rsp_valid_out <= 1'b1;
        rsp_data_out <= val;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hvmcr_pkg::*;
  logic ref_clk, sys_rst, rdy, s_vld, off_n, dual, miss, c_req, i_req, o_req, rstrt, mute;
  logic [15:0] s_dat, mode, a;
  logic [NFAULT-1:0] flt;
  logic [7:0] dly;
  logic [24:0] e_q;
  logic [24:0] expq[$];
  hvmcr_req_t req;
  hvmcr_rsp_t rsp;
  hvmcr_relay_t rly;
  hvmcr_act_t act;
  int n_fail, total_checks, n_rst, k;
  hvmcr_regs #(.SEC_CYCLES(10), .KEY_CYCLES(50), .RELAY_CYCLES(20), .FAULT_WINDOW(5)) dut (
    .ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .host_req_in(req), .host_ready_out(rdy),
    .host_rsp_out(rsp), .relay_req_out(rly), .slave_rsp_valid_in(s_vld),
    .slave_rsp_data_in(s_dat), .fault_event_in(flt), .unit_off_normal_in(off_n),
    .unit_mode_in(mode), .dual_valve_model_in(dual), .evap_target_missed_in(miss),
    .comp_request_in(c_req), .indoor_fan_request_in(i_req), .outdoor_fan_request_in(o_req),
    .act_out(act), .system_restart_out(rstrt));
  hvmcr_slave_model sm (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .relay_req_in(rly),
    .mute_in(mute), .delay_in(dly), .rsp_valid_out(s_vld), .rsp_data_out(s_dat));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  always #20 ref_clk = ~ref_clk;
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One host request; expectation noted first, held until accepted
  task automatic op(input logic [7:0] f, input logic [15:0] ad, input logic [15:0] d,
                    input logic [7:0] ex, input logic [15:0] ed, input logic cd);
    int i;
    i = 0;
    expq.push_back({cd, ex, ed});
    @(negedge ref_clk);
    req = '{1'b1, f, ad, d};
    do begin
      @(posedge ref_clk);
      i++;
    end while (rdy !== 1'b1 && i < 100);
    if (i >= 100) begin
      n_fail++;
      $display("Error host_ready expected 1 seen %b", rdy);
      close_out();
    end
    @(negedge ref_clk);
    req.valid = 1'b0;
  endtask
  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    op(FN_WRITE_SINGLE, ad, d, EXC_NONE, d, 1'b1);
  endtask
  task automatic kw(input logic [15:0] ad, input logic [15:0] d);
    op(FN_WRITE_SINGLE, ad, d, EXC_NONE, d, 1'b0);
  endtask
  task automatic rd(input logic [15:0] ad, input logic [15:0] e);
    op(FN_READ_HOLDING, ad, 16'h0000, EXC_NONE, e, 1'b1);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic fault(input int c);
    @(negedge ref_clk);
    flt[c] = 1'b1;
    @(negedge ref_clk);
    flt[c] = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Response watcher takes the oldest note on each answer
  always @(negedge ref_clk) begin
    if (rstrt === 1'b1) n_rst++;
    if (rsp.valid === 1'b1) begin
      if (expq.size() == 0) begin
        n_fail++;
        $display("Error rsp expected none seen %h", rsp.data);
      end else begin
        e_q = expq.pop_front();
        chk("rsp_exc", {8'h00, e_q[23:16]}, {8'h00, rsp.exc});
        if (e_q[24]) chk("rsp_data", e_q[15:0], rsp.data);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    req = '0;
    flt = '0;
    {off_n, miss} = 2'b00;
    {dual, c_req, i_req, o_req} = 4'hf;
    mute = 1'b0;
    dly = 8'h03;
    {n_fail, total_checks, n_rst} = '0;
    void'($urandom(57));
    mode = 16'($urandom_range(0, 11));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(ADDR_OPERATING_STATE, mode);
    wr(ADDR_LOW_NOISE_SELECT, 16'h0001);
    idle(3);
    chk("quiet", 16'h0000, {15'h0, act.outdoor_target_quiet});
    wr(ADDR_HOST_WRITE_ENABLE, 16'h0618);
    wr(ADDR_LOW_NOISE_SELECT, 16'h0001);
    wr(ADDR_INDOOR_FAN_BEHAVIOUR, 16'h0001);
    wr(ADDR_VALVE_ARRANGEMENT, VALVE_DUAL);
    wr(ADDR_DEHUMIDIFY_SELECT, 16'h0001);
    idle(3);
    chk("quiet", 16'h0001, {15'h0, act.outdoor_target_quiet});
    chk("indoor_fan", 16'h0001, {15'h0, act.indoor_fan_en});
    chk("fan_fixed", 16'h0001, {15'h0, act.fan_fixed});
    chk("dry_on", 16'h0001, {15'h0, act.dry_on});
    chk("dry", 16'h0002, {13'h0, act.super_dry, act.evap_by_valves, act.fan_vary});
    rd(ADDR_VALVE_ARRANGEMENT, VALVE_DUAL);
    // Super drying, a missed target, then conventional valves
    wr(ADDR_INDOOR_FAN_BEHAVIOUR, 16'h0000);
    idle(2);
    chk("dry", 16'h0006, {13'h0, act.super_dry, act.evap_by_valves, act.fan_vary});
    miss = 1'b1;
    idle(2);
    chk("dry", 16'h0007, {13'h0, act.super_dry, act.evap_by_valves, act.fan_vary});
    wr(ADDR_VALVE_ARRANGEMENT, VALVE_CONVENTIONAL);
    idle(2);
    chk("dry", 16'h0001, {13'h0, act.super_dry, act.evap_by_valves, act.fan_vary});
    op(FN_WRITE_COIL, COIL_QUIET_ENABLE, 16'h0000, EXC_NONE, 16'h0000, 1'b0);
    wr(ADDR_LOW_NOISE_SELECT, 16'h0000);
    idle(3);
    chk("quiet", 16'h0001, {15'h0, act.outdoor_target_quiet});
    op(FN_WRITE_COIL, COIL_QUIET_ENABLE, COIL_ON, EXC_NONE, 16'h0000, 1'b0);
    wr(ADDR_LOW_NOISE_SELECT, 16'h0000);
    op(FN_WRITE_COIL, COIL_QUIET_SELECT, COIL_ON, EXC_NONE, 16'h0000, 1'b0);
    idle(3);
    chk("quiet", 16'h0001, {15'h0, act.outdoor_target_quiet});
    op(FN_WRITE_SINGLE, ADDR_OPERATING_STATE, 16'h0001, EXC_ILLEGAL_ADDRESS, '0, 1'b0);
    // Relayed reads to each slave, then a wrong function and a silent slave
    for (k = 1; k < 4; k++) begin
      dly = 8'($urandom_range(0, 12));
      a = 16'(7 + k);
      rd(16'(k * 2000) + a, {k[1:0], a[13:0]} ^ 16'h5a00);
    end
    op(FN_WRITE_SINGLE, 16'd2007, 16'h0001, EXC_ILLEGAL_FUNCTION, '0, 1'b0);
    mute = 1'b1;
    op(FN_READ_HOLDING, 16'd4001, 16'h0000, EXC_GATEWAY_TIMEOUT, '0, 1'b0);
    idle(25);
    mute = 1'b0;
    // Lockout, late and prompt unlock keys
    for (k = 0; k < 3; k++) fault(1);
    idle(2);
    chk("locked", 16'h0001, {15'h0, act.locked});
    chk("comp", 16'h0000, {13'h0, act.comp_en, act.indoor_fan_en, act.outdoor_fan_en});
    rd(ADDR_OPERATING_STATE, STATE_LOCKOUT);
    kw(ADDR_COMMAND_KEY, KEY_UNLOCK_1);
    idle(60);
    kw(ADDR_COMMAND_KEY, KEY_UNLOCK_2);
    idle(3);
    chk("locked", 16'h0001, {15'h0, act.locked});
    kw(ADDR_COMMAND_KEY, KEY_UNLOCK_1);
    kw(ADDR_COMMAND_KEY, KEY_UNLOCK_2);
    idle(3);
    chk("locked", 16'h0000, {15'h0, act.locked});
    fault(2);
    fault(2);
    off_n = 1'b1;
    idle(1);
    off_n = 1'b0;
    fault(2);
    idle(2);
    chk("locked", 16'h0000, {15'h0, act.locked});
    fault(0);
    fault(0);
    idle(100);
    fault(0);
    idle(2);
    chk("locked", 16'h0000, {15'h0, act.locked});
    // System reset keys, wrong order first
    for (k = 0; k < 3; k++) fault(3);
    kw(ADDR_COMMAND_KEY, KEY_RESET_GO);
    kw(ADDR_RESET_ARM_KEY, KEY_RESET_ARM);
    kw(ADDR_COMMAND_KEY, KEY_RESET_GO);
    idle(4);
    chk("restarts", 16'h0001, 16'(n_rst));
    chk("locked", 16'h0000, {15'h0, act.locked});
    chk("quiet", 16'h0000, {15'h0, act.outdoor_target_quiet});
    for (k = 0; k < 100 && expq.size() > 0; k++) @(negedge ref_clk);
    if (expq.size() > 0) begin
      n_fail++;
      $display("Error rsp_left expected 0 seen %0d", expq.size());
    end
    close_out();
  end
endmodule
`default_nettype wire
